//--- logic/load_detect_pkg.sv
// Constants, register map and carrier types of the charge port load detector.
// Assumes a 20 MHz APB clock and comparator levels already synchronous to it.
package load_detect_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned PW_IDLE_S = 15;
  localparam int unsigned PW_IDLE_CYC = PW_IDLE_S * CLK_HZ;
  localparam int unsigned LD_ASSERT_MS = 200;
  localparam int unsigned LD_ASSERT_CYC = LD_ASSERT_MS * (CLK_HZ / 1000);
  localparam int unsigned LD_RELEASE_S = 3;
  localparam int unsigned LD_RELEASE_CYC = LD_RELEASE_S * CLK_HZ;
  localparam int unsigned DISCH_S = 2;
  localparam int unsigned DISCH_CYC = DISCH_S * CLK_HZ;

  // ==========================================================================
  // Register map
  localparam int unsigned APB_ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATE = 12'h004;
  localparam logic [11:0] ADDR_INT_STAT = 12'h008;
  localparam logic [11:0] ADDR_INT_MASK = 12'h00c;
  localparam int unsigned CTRL_MODE_MSB = 3;
  localparam int unsigned CTRL_EN_BIT = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam int unsigned EV_LOAD_ON = 0;
  localparam int unsigned EV_LOAD_OFF = 1;
  localparam int unsigned EV_AUTOSW = 2;
  localparam int unsigned EV_THERMAL = 3;
  localparam int unsigned EV_W = 4;

  // ==========================================================================
  // Mode codes: {mode_control_pins, limit_select}
  localparam logic [3:0] MODE_PW = 4'h3;
  localparam logic [3:0] MODE_DCP_LD = 4'h7;
  localparam logic [3:0] MODE_STD_ALT = 4'he;
  localparam logic [3:0] MODE_CDP = 4'hf;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_RUN = 3'b001,
    ST_PW_IDLE = 3'b010,
    ST_PW_DISCH = 3'b011,
    ST_AS_DISCH = 3'b100,
    ST_AS_SDP = 3'b101
  } fsm_type;

  typedef enum logic [1:0] {
    LIM_HI = 2'b00,
    LIM_LO = 2'b01,
    LIM_PW = 2'b10
  } lim_type;

  typedef struct packed {
    logic below_pw;
    logic at_pw_limit;
    logic above_lo_60;
    logic below_lo_10;
    logic primary_detect;
    logic misclass;
    logic data_connected;
    logic out_short;
    logic over_temp;
    logic cooled;
  } sense_type;

  typedef struct packed {
    lim_type limit;
    logic switch_en;
    logic discharge;
    logic const_current;
    logic data_connect;
    logic cdp_signature;
    logic load_present_n;
  } port_ctl_type;

  typedef struct packed {
    fsm_type fsm;
    logic [31:0] timer;
    logic [3:0] mode_prev;
    logic load;
    logic thermal_off;
    port_ctl_type port;
    logic [4:0] ctrl;
    logic [EV_W-1:0] int_status;
    logic [EV_W-1:0] int_mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_type;

  localparam state_type STATE_RESET = '{
    fsm: ST_OFF,
    port: '{limit: LIM_HI, load_present_n: 1'b1, default: 1'b0},
    ctrl: CTRL_RESET,
    default: '0
  };

endpackage

//--- logic/charge_port_load_detect.sv
// Load detection, power wake and CDP/SDP auto switch control of a charge port.
// Assumes comparator and detector levels on sense are synchronous to pclk.
`timescale 1ns/1ps

module charge_port_load_detect import load_detect_pkg::*; #(
  parameter int unsigned PW_IDLE_CYCLES = PW_IDLE_CYC,
  parameter int unsigned LD_ASSERT_CYCLES = LD_ASSERT_CYC,
  parameter int unsigned LD_RELEASE_CYCLES = LD_RELEASE_CYC,
  parameter int unsigned DISCH_CYCLES = DISCH_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port sensing
  input wire sense_type sense,
  // Port control
  output port_ctl_type port_ctl,
  // Interrupt
  output logic irq
);

  // ==========================================================================
  // Elaboration checks
  if (PW_IDLE_CYCLES < 1 || LD_ASSERT_CYCLES < 1 || LD_RELEASE_CYCLES < 1 ||
      DISCH_CYCLES < 1) begin : g_bad_count
    $error("duration counts must be at least one cycle");
  end

  // ==========================================================================
  // Decode
  state_type s;
  state_type n;
  logic [3:0] mode;
  logic port_off;
  logic mode_changed;
  logic apb_first;
  logic apb_commit;
  logic addr_ok;
  logic wr_ok;
  logic [31:0] rdata;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;
  logic lim_low;

  assign mode = s.ctrl[CTRL_MODE_MSB:0];
  assign port_off = !s.ctrl[CTRL_EN_BIT] || (mode[3:1] == 3'b000);
  assign mode_changed = mode != s.mode_prev;
  assign apb_first = psel && penable && !s.pready;
  assign apb_commit = psel && penable && s.pready && pwrite && pstrb[0] && !s.pslverr;
  assign lim_low = !mode[0] && (mode[3] || !mode[1]);

  always_comb begin
    rdata = 32'h0;
    addr_ok = 1'b1;
    wr_ok = 1'b1;
    case (paddr)
      ADDR_CTRL: rdata = {27'h0, s.ctrl};
      ADDR_STATE: begin
        rdata = {20'h0, s.fsm, s.thermal_off, s.port.cdp_signature, s.port.data_connect,
                 s.port.const_current, s.port.switch_en, s.port.discharge, s.port.limit,
                 s.load};
        wr_ok = 1'b0;
      end
      ADDR_INT_STAT: rdata = {28'h0, s.int_status};
      ADDR_INT_MASK: rdata = {28'h0, s.int_mask};
      default: begin
        addr_ok = 1'b0;
        wr_ok = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    n = s;
    ev = '0;
    clr = '0;
    n.mode_prev = mode;

    // Port sequencer
    if (port_off) begin
      n.fsm = ST_OFF;
      n.load = 1'b0;
      n.timer = 32'h0;
    end else if (mode_changed || s.fsm == ST_OFF) begin
      n.fsm = ST_RUN;
      n.timer = 32'h0;
      n.load = (mode == MODE_PW);
    end else begin
      unique case (s.fsm)
        ST_RUN: begin
          if (mode == MODE_PW) begin
            if (!sense.below_pw) begin
              n.timer = 32'h0;
            end else if (s.timer == PW_IDLE_CYCLES - 1) begin
              n.fsm = ST_PW_IDLE;
              n.load = 1'b0;
              n.timer = 32'h0;
            end else begin
              n.timer = s.timer + 32'h1;
            end
          end else if (mode == MODE_DCP_LD || mode == MODE_CDP) begin
            if (mode == MODE_CDP && sense.misclass) begin
              n.fsm = ST_AS_DISCH;
              n.timer = 32'h0;
            end else if (!s.load) begin
              if (mode == MODE_CDP && sense.primary_detect) begin
                n.load = 1'b1;
                n.timer = 32'h0;
              end else if (!sense.above_lo_60) begin
                n.timer = 32'h0;
              end else if (s.timer == LD_ASSERT_CYCLES - 1) begin
                n.load = 1'b1;
                n.timer = 32'h0;
              end else begin
                n.timer = s.timer + 32'h1;
              end
            end else begin
              if (!sense.below_lo_10) begin
                n.timer = 32'h0;
              end else if (s.timer == LD_RELEASE_CYCLES - 1) begin
                n.load = 1'b0;
                n.timer = 32'h0;
              end else begin
                n.timer = s.timer + 32'h1;
              end
            end
          end else begin
            n.load = 1'b0;
            n.timer = 32'h0;
          end
        end
        ST_PW_IDLE: begin
          if (sense.at_pw_limit) begin
            n.fsm = ST_PW_DISCH;
            n.load = 1'b1;
            n.timer = 32'h0;
          end
        end
        ST_PW_DISCH, ST_AS_DISCH: begin
          if (s.timer == DISCH_CYCLES - 1) begin
            n.fsm = (s.fsm == ST_PW_DISCH) ? ST_RUN : ST_AS_SDP;
            n.timer = 32'h0;
          end else begin
            n.timer = s.timer + 32'h1;
          end
        end
        ST_AS_SDP: begin
          if (sense.data_connected) begin
            n.fsm = ST_RUN;
            ev[EV_AUTOSW] = 1'b1;
          end
        end
        default: n.fsm = ST_OFF;
      endcase
    end

    if (sense.over_temp && !s.thermal_off) begin
      n.thermal_off = 1'b1;
      ev[EV_THERMAL] = 1'b1;
    end else if (s.thermal_off && sense.cooled && !sense.over_temp) begin
      n.thermal_off = 1'b0;
    end

    // Port pins
    n.port.discharge = (n.fsm == ST_OFF) || (n.fsm == ST_PW_DISCH) || (n.fsm == ST_AS_DISCH);
    n.port.switch_en = !n.port.discharge && !n.thermal_off;
    n.port.const_current = n.port.switch_en && sense.out_short;
    if (n.fsm == ST_PW_IDLE) begin
      n.port.limit = LIM_PW;
    end else if (lim_low && n.fsm == ST_RUN) begin
      n.port.limit = LIM_LO;
    end else begin
      // trip point is not a limit
      n.port.limit = LIM_HI;
    end
    n.port.data_connect = mode[2] && (mode[3] || !mode[1]) && !port_off;
    n.port.cdp_signature = (mode == MODE_CDP) && (n.fsm == ST_RUN);
    n.port.load_present_n = !n.load;

    ev[EV_LOAD_ON] = n.load && !s.load;
    ev[EV_LOAD_OFF] = !n.load && s.load;

    // APB answer one cycle into the access phase
    n.pready = apb_first;
    n.pslverr = apb_first && (!addr_ok || (pwrite && !wr_ok));
    if (apb_first) begin
      n.prdata = (pwrite || !addr_ok) ? 32'h0 : rdata;
    end
    if (apb_commit && paddr == ADDR_CTRL) begin
      n.ctrl = pwdata[4:0];
    end
    if (apb_commit && paddr == ADDR_INT_MASK) begin
      n.int_mask = pwdata[EV_W-1:0];
    end
    if (apb_commit && paddr == ADDR_INT_STAT) begin
      clr = pwdata[EV_W-1:0];
    end
    // New event wins over clear
    n.int_status = (s.int_status & ~clr) | ev;
    n.irq = |(n.int_status & n.int_mask);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= STATE_RESET;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign port_ctl = s.port;
  assign irq = s.irq;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PW_ONLY_IN_MODE: assert property (
    (s.fsm == ST_PW_IDLE || s.fsm == ST_PW_DISCH) |-> s.mode_prev == MODE_PW)
    else $error("power wake state outside mode 0011");

  AST_PW_IDLE_ENTRY: assert property (
    (s.fsm == ST_PW_IDLE && $past(s.fsm) == ST_RUN) |->
      ($past(s.timer) == PW_IDLE_CYCLES - 1 && !s.load && s.port.limit == LIM_PW &&
       s.port.load_present_n))
    else $error("wake idle entered without full quiet interval");

  AST_PW_REATTACH: assert property (
    (s.fsm == ST_PW_IDLE && sense.at_pw_limit && s.mode_prev == MODE_PW &&
     mode == MODE_PW && s.ctrl[CTRL_EN_BIT]) |=> (s.fsm == ST_PW_DISCH && !s.port.load_present_n))
    else $error("wake limit hit did not assert indication");

  AST_PW_DISCH_LEN: assert property (
    ($past(s.fsm) == ST_PW_DISCH && s.fsm == ST_RUN && s.mode_prev == $past(s.mode_prev)) |->
      ($past(s.timer) == DISCH_CYCLES - 1 && s.port.limit == LIM_HI && s.port.switch_en == !s.thermal_off))
    else $error("wake discharge ended early or wrong limit");

  AST_SDP_LOW_LIMIT: assert property (
    (s.fsm == ST_RUN && s.mode_prev == MODE_STD_ALT) |-> s.port.limit == LIM_LO)
    else $error("standard port not on low limit");

  AST_NO_DISCH_TO_CDP: assert property (
    ($past(s.mode_prev) == MODE_STD_ALT && s.mode_prev == MODE_CDP && $past(s.fsm) == ST_RUN &&
     s.fsm != ST_OFF) |-> !s.port.discharge)
    else $error("discharge on alternate standard to downstream change");

  AST_ASSERT_200MS: assert property (
    ($rose(s.load) && s.mode_prev == MODE_DCP_LD) |-> $past(s.timer) == LD_ASSERT_CYCLES - 1)
    else $error("indication asserted before 200 ms");

  AST_PRIMARY_DET: assert property (
    (s.fsm == ST_RUN && s.mode_prev == MODE_CDP && mode == MODE_CDP && s.ctrl[CTRL_EN_BIT] &&
     sense.primary_detect && !sense.misclass) |=> !s.port.load_present_n)
    else $error("primary detection did not assert indication");

  AST_RELEASE_3S: assert property (
    ($fell(s.load) && $past(s.fsm) == ST_RUN && s.fsm == ST_RUN &&
     s.mode_prev == $past(s.mode_prev) && s.mode_prev == MODE_DCP_LD) |->
      $past(s.timer) == LD_RELEASE_CYCLES - 1)
    else $error("indication released before 3 s");

  AST_CDP_HIGH_LIMIT: assert property (
    (s.fsm == ST_RUN && (s.mode_prev == MODE_CDP || s.mode_prev == MODE_PW))
      |-> s.port.limit == LIM_HI)
    else $error("detection mode not on high limit");

  AST_AUTOSW_DISCH: assert property (
    (s.fsm == ST_AS_DISCH) |-> (s.port.discharge && !s.port.switch_en && !s.port.cdp_signature))
    else $error("auto switch discharge not applied");

  AST_AUTOSW_RETURN: assert property (
    ($past(s.fsm) == ST_AS_SDP && s.fsm == ST_RUN && s.mode_prev == $past(s.mode_prev)) |->
      (!s.port.discharge && s.int_status[EV_AUTOSW]))
    else $error("auto switch return discharged output");

  AST_SHORT_CC: assert property (
    (sense.out_short && n.port.switch_en) |=> s.port.const_current)
    else $error("short at enable without constant current");

  AST_THERMAL_OFF: assert property (
    s.thermal_off |-> !s.port.switch_en)
    else $error("switch on during thermal shutdown");

  AST_TIMER_RESTART: assert property (
    ($past(s.fsm) == ST_RUN && s.mode_prev == MODE_DCP_LD && !$past(s.load) &&
     !$past(sense.above_lo_60)) |-> s.timer == 32'h0)
    else $error("assert timer not restarted on break");

  AST_IRQ_LEVEL: assert property (
    s.irq == |(s.int_status & s.int_mask))
    else $error("interrupt output not tracking masked status");

  AST_SHARE_HIGH: assert property (
    (s.fsm == ST_RUN && s.mode_prev == MODE_DCP_LD) |-> s.port.limit == LIM_HI)
    else $error("dedicated charging port not on high limit");

  AST_MISCLASS_SEEN: assert property (
    (s.fsm == ST_RUN && s.mode_prev == MODE_CDP && mode == MODE_CDP && s.ctrl[CTRL_EN_BIT] &&
     sense.misclass) |=> s.fsm == ST_AS_DISCH)
    else $error("misclassified phone not detected");

  AST_AUTOSW_STD_PORT: assert property (
    (s.fsm == ST_AS_SDP) |->
      (!s.port.cdp_signature && !s.port.discharge && s.port.data_connect))
    else $error("auto switch not showing a standard port");

  AST_WAKE_LIMIT: assert property (
    (s.fsm == ST_PW_IDLE) |-> s.port.limit == LIM_PW)
    else $error("wake idle without wake limit");

  AST_APB_ONE_WAIT: assert property (
    (psel && penable && !s.pready) |=> s.pready)
    else $error("access phase not answered after one wait state");

  AST_ERR_WITH_READY: assert property (
    s.pslverr |-> s.pready)
    else $error("error response outside ready cycle");

  COV_PW_IDLE: cover property (s.fsm == ST_RUN ##1 s.fsm == ST_PW_IDLE);
  COV_AUTOSW: cover property (s.fsm == ST_AS_SDP ##1 s.fsm == ST_RUN);
  COV_THERMAL: cover property ($rose(s.thermal_off));
  COV_CDP_LOAD: cover property ($rose(s.load) && s.mode_prev == MODE_CDP);
  COV_STD_ALT_TO_CDP: cover property (s.mode_prev == MODE_STD_ALT ##1 s.mode_prev == MODE_CDP);

endmodule // charge_port_load_detect

//--- tb/port_load_model.sv
// Far side model: phone load current, detection events and die heat.
// Assumes the bench sets load_ma and event flags just after rising edges.
`timescale 1ns/1ps

module port_load_model import load_detect_pkg::*; #(
  parameter int LO_MA = 900
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench stimulus
  input wire logic [15:0] load_ma,
  input wire logic detect,
  input wire logic confused,
  input wire logic shorted,
  input wire logic hot,
  // Port
  input wire port_ctl_type port_ctl,
  output sense_type sense
);
  // ==========================================================================
  // Comparators, one cycle like a synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense <= '0;
    end else begin
      sense.below_pw <= load_ma < 16'd45;
      sense.at_pw_limit <= port_ctl.limit == LIM_PW && load_ma > 16'd55;
      sense.above_lo_60 <= load_ma > 16'(LO_MA + 60);
      sense.below_lo_10 <= load_ma < 16'(LO_MA + 10);
      sense.primary_detect <= detect;
      sense.misclass <= confused;
      // phone links only to a live standard port
      sense.data_connected <= port_ctl.data_connect && !port_ctl.cdp_signature &&
                              port_ctl.switch_en;
      sense.out_short <= shorted;
      sense.over_temp <= hot && port_ctl.switch_en;
      sense.cooled <= !hot;
    end
  end
endmodule // port_load_model

//--- tb/tb.sv
// Self-checking bench of the charge port load detector.
// Assumes port_load_model drives sense; the bench is APB master and system.
`timescale 1ns/1ps

module tb import load_detect_pkg::*; ;
  // Short timers keep the run brief
  localparam int PW = 20;
  localparam int LDA = 8;
  localparam int LDR = 12;
  localparam int DIS = 6;
  localparam int LO = 900;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  sense_type sense;
  port_ctl_type port_ctl;
  logic [15:0] load_ma;
  logic detect, confused, shorted, hot, saw_sdp, rerr;
  logic [31:0] rdata;
  int seed = 88;
  int failures = 0;
  int tests_run = 0;

  charge_port_load_detect #(.PW_IDLE_CYCLES(PW), .LD_ASSERT_CYCLES(LDA),
    .LD_RELEASE_CYCLES(LDR), .DISCH_CYCLES(DIS)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense),
    .port_ctl(port_ctl), .irq(irq));
  port_load_model #(.LO_MA(LO)) phone (.pclk(pclk), .presetn(presetn),
    .load_ma(load_ma), .detect(detect), .confused(confused),
    .shorted(shorted), .hot(hot), .port_ctl(port_ctl), .sense(sense));

  // ==========================================================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Of the modes this bench uses, only a parked standard port drops to the low limit
  function automatic lim_type want_limit(input logic [3:0] m);
    return (m == MODE_STD_ALT) ? LIM_LO : LIM_HI;
  endfunction

  // Entered just after an edge; leaves one idle cycle behind
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb wait", 2, n);
    @(posedge pclk);
  endtask

  task automatic fin(input string name);
    $display("test %s finished", name);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    cyc(3000);
    failures++;
    conclude();
  end

  // ==========================================================================
  // Tests
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    load_ma = 16'd20;
    {detect, confused, shorted, hot, saw_sdp} = 5'h00;
    cyc(5);
    presetn <= 1'b1;
    cyc(3);
    chk("off discharge", 1, port_ctl.discharge);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", 0, rdata);
    apb(1'b0, ADDR_INT_MASK, 32'h0);
    chk("mask reset", 0, rdata);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", 1, rerr);
    chk("unmapped data", 0, rdata);
    apb(1'b1, ADDR_STATE, 32'hff);
    chk("state ro err", 1, rerr);
    pstrb <= 4'h0;
    apb(1'b1, ADDR_INT_MASK, 32'hf);
    pstrb <= 4'hf;
    apb(1'b0, ADDR_INT_MASK, 32'h0);
    chk("strobe off", 0, rdata);
    fin("registers");

    apb(1'b1, ADDR_CTRL, {28'h1, MODE_PW});
    cyc(2);
    chk("wake charging", 0, port_ctl.load_present_n);
    cyc(PW - 8);
    load_ma <= 16'd50;
    cyc(1);
    load_ma <= 16'd20;
    cyc(PW - 3);
    chk("idle restart", 0, port_ctl.load_present_n);
    cyc(8);
    chk("idle release", 1, port_ctl.load_present_n);
    chk("wake limit", LIM_PW, port_ctl.limit);
    load_ma <= 16'd100;
    cyc(4);
    chk("reattach", 0, port_ctl.load_present_n);
    chk("wake discharge", 1, port_ctl.discharge);
    cyc(DIS + 4);
    chk("after discharge", 0, port_ctl.discharge);
    chk("back high", LIM_HI, port_ctl.limit);
    fin("power wake");

    load_ma <= 16'(LO + 61 + ($random(seed) & 255));
    apb(1'b1, ADDR_CTRL, {28'h1, MODE_CDP});
    cyc(2);
    chk("cdp limit", want_limit(MODE_CDP), port_ctl.limit);
    cyc(LDA - 5);
    chk("assert early", 1, port_ctl.load_present_n);
    cyc(8);
    chk("assert", 0, port_ctl.load_present_n);
    chk("limit kept", LIM_HI, port_ctl.limit);
    load_ma <= 16'(LO - 1 - ($random(seed) & 255));
    cyc(LDR - 3);
    chk("release early", 0, port_ctl.load_present_n);
    cyc(8);
    chk("release", 1, port_ctl.load_present_n);
    load_ma <= 16'(LO + 30);
    detect <= 1'b1;
    cyc(1);
    detect <= 1'b0;
    cyc(4);
    chk("primary detect", 0, port_ctl.load_present_n);
    // Bench as system: quota reached, park this port
    apb(1'b1, ADDR_CTRL, {28'h1, MODE_STD_ALT});
    cyc(2);
    chk("sdp low limit", want_limit(MODE_STD_ALT), port_ctl.limit);
    apb(1'b1, ADDR_CTRL, {28'h1, MODE_CDP});
    repeat (4) begin
      cyc(1);
      chk("no discharge", 0, port_ctl.discharge);
    end
    chk("cdp again", want_limit(MODE_CDP), port_ctl.limit);
    fin("sharing");

    chk("irq masked", 0, irq);
    apb(1'b1, ADDR_INT_MASK, 32'h1);
    cyc(1);
    chk("irq raised", 1, irq);
    apb(1'b1, ADDR_INT_STAT, 32'hf);
    apb(1'b1, ADDR_INT_MASK, 32'h4);
    cyc(1);
    chk("irq cleared", 0, irq);
    saw_sdp = 1'b0;
    confused <= 1'b1;
    cyc(1);
    confused <= 1'b0;
    cyc(3);
    chk("auto discharge", 1, port_ctl.discharge);
    // Standard port shows for a few cycles only
    repeat (DIS + 6) begin
      cyc(1);
      if (port_ctl.data_connect && !port_ctl.cdp_signature && !port_ctl.discharge) begin
        saw_sdp = 1'b1;
      end
    end
    chk("sdp shown", 1, saw_sdp);
    chk("no second discharge", 0, port_ctl.discharge);
    chk("cdp restored", 1, port_ctl.cdp_signature);
    chk("irq autosw", 1, irq);
    apb(1'b0, ADDR_INT_STAT, 32'h0);
    chk("autosw status", 1, rdata[EV_AUTOSW]);
    fin("auto switch");

    shorted <= 1'b1;
    cyc(4);
    chk("const current", 1, port_ctl.const_current);
    shorted <= 1'b0;
    hot <= 1'b1;
    cyc(4);
    chk("thermal off", 0, port_ctl.switch_en);
    apb(1'b0, ADDR_INT_STAT, 32'h0);
    chk("thermal status", 1, rdata[EV_THERMAL]);
    hot <= 1'b0;
    cyc(4);
    chk("restart", 1, port_ctl.switch_en);
    apb(1'b1, ADDR_CTRL, 32'h0);
    cyc(2);
    chk("off again", 1, port_ctl.discharge);
    fin("protection");

    // Dedicated charging: primary detection must not count here
    load_ma <= 16'(LO + 61 + ($random(seed) & 255));
    detect <= 1'b1;
    apb(1'b1, ADDR_CTRL, {28'h1, MODE_DCP_LD});
    cyc(LDA - 3);
    chk("dcp early", 1, port_ctl.load_present_n);
    detect <= 1'b0;
    cyc(6);
    chk("dcp assert", 0, port_ctl.load_present_n);
    chk("dcp limit", want_limit(MODE_DCP_LD), port_ctl.limit);
    load_ma <= 16'(LO - 1 - ($random(seed) & 255));
    cyc(6);
    load_ma <= 16'(LO + 30);
    cyc(1);
    load_ma <= 16'(LO - 1);
    cyc(LDR - 2);
    chk("dcp restart", 0, port_ctl.load_present_n);
    cyc(5);
    chk("dcp release", 1, port_ctl.load_present_n);
    fin("dedicated");
    conclude();
  end
endmodule // tb
